/* File: rtl/rcr_pkg.sv */
// Shared constants and carrier types for the ray-cast renderer control block.
// Assumes a single 40 MHz clock domain; no timing figures are carried here.
package rcr_pkg;
   localparam int RCR_LANES       = 2;                       // Parallel ray lanes
   localparam int RCR_SCREEN_COLS = 320;                     // Pixels per screen row
   localparam int RCR_STEP_LIMIT  = RCR_SCREEN_COLS / RCR_LANES;
   localparam int RCR_COORD_W     = 9;                       // Coordinate and slope width
   localparam int RCR_COLOR_W     = 8;
   localparam int RCR_ROW_W       = 8;
   localparam int RCR_COL_W       = 9;                       // Scan-out column index width
   localparam int RCR_STEP_W      = 8;                       // Column step counter width
   localparam int RCR_RECT_AW     = 4;                       // Rectangle store address width
   localparam int RCR_BUF_DEPTH   = 2;                       // Read-path buffer entries

   localparam logic [RCR_STEP_W-1:0]  RCR_STEP_MAX  = RCR_STEP_W'(RCR_STEP_LIMIT);
   localparam logic [RCR_STEP_W-1:0]  RCR_STEP_ONE  = 8'h01;
   localparam logic [RCR_STEP_W-1:0]  RCR_STEP_ZERO = 8'h00;
   localparam logic [RCR_ROW_W-1:0]   RCR_ROW_ONE   = 8'h01;
   localparam logic [RCR_ROW_W-1:0]   RCR_ROW_ZERO  = 8'h00;
   localparam logic [RCR_RECT_AW-1:0] RCR_RECT_ONE  = 4'h1;
   localparam logic [RCR_RECT_AW-1:0] RCR_RECT_ZERO = 4'h0;
   localparam int                     RCR_HALF_BIT  = 0;     // Row bit that picks the line half

   // A ray: origin and slopes
   typedef struct packed {
      logic [RCR_COORD_W-1:0] x;
      logic [RCR_COORD_W-1:0] y;
      logic [RCR_COORD_W-1:0] z;
      logic [RCR_COORD_W-1:0] dx;
      logic [RCR_COORD_W-1:0] dy;
      logic [RCR_COORD_W-1:0] dz;
   } rcr_ray_t;

   // Hit solver answer: hit point with reflected slopes, distance and colour
   typedef struct packed {
      rcr_ray_t               refl;
      logic [RCR_COORD_W-1:0] depth;
      logic [RCR_COLOR_W-1:0] color;
   } rcr_hit_t;

   // One rectangle as held in the rectangle store
   typedef struct packed {
      logic [RCR_COORD_W-1:0] x0;
      logic [RCR_COORD_W-1:0] y0;
      logic [RCR_COORD_W-1:0] z0;
      logic [RCR_COORD_W-1:0] x1;
      logic [RCR_COORD_W-1:0] y1;
      logic [RCR_COORD_W-1:0] z1;
      logic [RCR_COLOR_W-1:0] color;
   } rcr_rect_t;

   // Lane control strobes driven by the sequencer
   typedef struct packed {
      logic clear_depth_store;
      logic clear_color_accum;
      logic primary_ray_select;
      logic depth_store_write;
      logic color_accumulate;
      logic save_reflected_ray;
   } rcr_lane_ctl_t;

   // Sequencer states, Gray coded along the usual path
   typedef enum logic [2:0] {
      RCR_IDLE   = 3'h0,
      RCR_CLEAR  = 3'h1,
      RCR_MAKE   = 3'h3,
      RCR_FETCH  = 3'h2,
      RCR_SOLVE  = 3'h6,
      RCR_DEPTH  = 3'h7,
      RCR_ACCUM  = 3'h5,
      RCR_DONE   = 3'h4
   } rcr_seq_t;
endpackage : rcr_pkg

/* File: rtl/rcr_pair_buffer.sv */
// Small valid/ready buffer on the scan-out read path.
// Assumes producer and consumer share the clock; depth shapes the pointer widths.
`timescale 1ns/1ps
module rcr_pair_buffer
   import rcr_pkg::*;
#(
   parameter int W     = RCR_COLOR_W,
   parameter int DEPTH = RCR_BUF_DEPTH
) (
   input  wire logic         i_clk,
   input  wire logic         i_reset,
   input  wire logic         i_ce,
   input  wire logic         i_valid,
   output logic              o_ready,
   input  wire logic [W-1:0] i_data,
   output logic              o_valid,
   input  wire logic         i_ready,
   output logic [W-1:0]      o_data,
   output logic [$clog2(DEPTH+1)-1:0] o_level
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH+1);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0]           wp;
      logic [PW-1:0]           rp;
      logic [CW-1:0]           cnt;
   } rcr_buf_state_t;

   rcr_buf_state_t s_r;
   rcr_buf_state_t s_nxt;
   logic           push;
   logic           pop;

   // Honest flags: full refuses, empty shows nothing
   assign o_ready = (s_r.cnt != CW'(DEPTH));
   assign o_valid = (s_r.cnt != '0);
   assign o_data  = s_r.mem[s_r.rp];
   assign o_level = s_r.cnt;
   assign push    = i_valid && o_ready;
   assign pop     = o_valid && i_ready;

   // Pointer wrap written out so a non power of two depth still works
   always_comb begin
      s_nxt = s_r;
      if (push) begin
         s_nxt.mem[s_r.wp] = i_data;
         s_nxt.wp = (s_r.wp == PW'(DEPTH-1)) ? '0 : s_r.wp + PW'(1);
      end
      if (pop) begin
         s_nxt.rp = (s_r.rp == PW'(DEPTH-1)) ? '0 : s_r.rp + PW'(1);
      end
      s_nxt.cnt = s_r.cnt + CW'(push) - CW'(pop);
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         s_r <= '0;
      end else if (i_ce) begin
         s_r <= s_nxt;
      end
   end
endmodule : rcr_pair_buffer

/* File: rtl/rcr_ray_lane.sv */
// One ray lane: ray select, nearest hit store, reflected ray store, colour accumulator.
// Assumes the ray maker and hit solver outside hold their outputs while strobes are applied.
`timescale 1ns/1ps
module rcr_ray_lane
   import rcr_pkg::*;
(
   input  wire logic                   i_clk,
   input  wire logic                   i_reset,
   input  wire logic                   i_ce,
   input  wire rcr_lane_ctl_t          i_ctl,
   input  wire rcr_ray_t               i_primary_ray,
   input  wire rcr_hit_t               i_hit,
   output rcr_ray_t                    o_solver_ray,
   output logic [RCR_COLOR_W-1:0]      o_color
);
   typedef struct packed {
      logic                   held;      // Nearest hit store holds a hit
      rcr_hit_t               nearest;
      rcr_ray_t               refl_ray;
      logic [RCR_COLOR_W-1:0] color;
      logic                   merged;    // Accumulator already holds a colour
   } rcr_lane_state_t;

   rcr_lane_state_t s_r;
   rcr_lane_state_t s_nxt;
   logic            closer;

   // Primary ray from the maker, otherwise the stored reflection
   assign o_solver_ray = i_ctl.primary_ray_select ? i_primary_ray : s_r.refl_ray; // RULE13
   assign o_color      = s_r.color;
   assign closer       = !s_r.held || (i_hit.depth < s_r.nearest.depth);

   always_comb begin
      s_nxt = s_r;
      if (i_ctl.clear_depth_store) begin
         s_nxt.held = 1'b0; // RULE11
      end
      if (i_ctl.clear_color_accum) begin
         s_nxt.color  = '0; // RULE11
         s_nxt.merged = 1'b0;
      end
      // Only a closer hit replaces the held one
      if (i_ctl.depth_store_write && closer) begin
         s_nxt.nearest = i_hit; // RULE15
         s_nxt.held    = 1'b1;
      end
      if (i_ctl.save_reflected_ray) begin
         s_nxt.refl_ray = s_r.nearest.refl; // RULE16
      end
      // Reflection blends as an average, so it cannot overflow the colour width
      if (i_ctl.color_accumulate) begin
         s_nxt.merged = 1'b1;
         if (s_r.merged) begin
            s_nxt.color = RCR_COLOR_W'(({1'b0, s_r.color} + {1'b0, s_r.nearest.color}) >> 1); // RULE17
         end else begin
            s_nxt.color = s_r.nearest.color; // RULE16
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         s_r <= '0;
      end else if (i_ce) begin
         s_r <= s_nxt;
      end
   end

   a_depth_keeps_near: assert property (@(posedge i_clk) disable iff (i_reset || !i_ce)
      (i_ctl.depth_store_write && !i_ctl.clear_depth_store && s_r.held && i_hit.depth >= s_r.nearest.depth)
      |=> (s_r.nearest == $past(s_r.nearest))) // RULE15
      else $error("farther hit replaced the nearest hit");
endmodule : rcr_ray_lane

/* File: rtl/rcr_renderer.sv */
// Ray-cast renderer control: counters, core reset and enable, sequencer, line buffer.
// Assumes the scan-out engine, ray maker, hit solver and rectangle store run on i_clk.
// Function
// RULE1: Screen start clears row, step counter, core.
// RULE2: Step limit is columns over lane count.
// RULE3: Row bit zero picks written line half.
// RULE4: Each half split into one section per lane.
// RULE5: Done writes buffer, steps counter, resets core.
// RULE6: Step count at limit stops core, freezes counter.
// RULE7: Core reset is OR of sources, synchronous.
// RULE8: Stretch flop holds core reset two cycles.
// RULE9: Scan-out read column independent of step counter.
// RULE10: One sequencer walks rectangles, orders lane strobes.
// RULE11: Clear depth and colour before any intersection.
// RULE12: Primary strobe makes ray maker give ray.
// RULE13: Select one uses maker ray, zero reflection.
// RULE14: Intersect strobe yields hit point, slopes, colour.
// RULE15: Depth store keeps only the closer hit.
// RULE16: After all rectangles accumulate colour, save ray.
// RULE17: Second pass uses reflection, merges colour.
// RULE18: Ray is six values, nine bits each.
// RULE19: System reset clears stretch, parks step counter.
`timescale 1ns/1ps
module rcr_renderer
   import rcr_pkg::*;
(
   input  wire logic                             i_clk,
   input  wire logic                             i_reset,
   input  wire logic                             i_ce,
   // Scan-out engine side
   input  wire logic                             i_screen_start_pulse,
   input  wire logic                             i_row_next,
   input  wire logic                             i_rd_valid,
   output logic                                  o_rd_ready,
   input  wire logic [RCR_COL_W-1:0]             i_rd_col,
   output logic                                  o_pix_valid,
   input  wire logic                             i_pix_ready,
   output logic [RCR_COLOR_W-1:0]                o_pix_color,
   output logic                                  o_line_half_select,
   // Ray maker side
   output logic                                  o_make_primary_ray,
   output logic [RCR_ROW_W-1:0]                  o_row_index,
   output logic [RCR_STEP_W-1:0]                 o_column_step_index,
   input  wire rcr_ray_t [RCR_LANES-1:0]         i_primary_ray,
   // Rectangle store side
   input  wire logic [RCR_RECT_AW-1:0]           i_rect_count,
   output logic [RCR_RECT_AW-1:0]                o_rect_addr,
   input  wire rcr_rect_t                        i_rect_data,
   // Hit solver side
   output logic                                  o_intersect_go,
   output rcr_rect_t                             o_active_rectangle,
   output rcr_ray_t [RCR_LANES-1:0]              o_solver_ray,
   input  wire logic                             i_hit_done,
   input  wire rcr_hit_t [RCR_LANES-1:0]         i_hit,
   // Status
   output logic                                  o_core_enable,
   output logic                                  o_core_done
);
   typedef struct packed {
      rcr_seq_t               st;
      logic                   pass;       // 0 primary pass, 1 reflection pass
      logic [RCR_RECT_AW-1:0] rect_idx;
      rcr_rect_t              rect;
      logic [RCR_ROW_W-1:0]   row;
      logic [RCR_STEP_W-1:0]  step;
      logic                   stretch;    // Reset stretch flop
      logic                   rd_pend;    // Line buffer read in flight
      logic [RCR_COLOR_W-1:0] rd_data;
   } rcr_core_state_t;

   rcr_core_state_t                     s_r;
   rcr_core_state_t                     s_nxt;
   logic [RCR_COLOR_W-1:0]              lbuf [2][RCR_SCREEN_COLS];
   logic [RCR_LANES-1:0][RCR_COLOR_W-1:0] lane_color;
   rcr_lane_ctl_t                       ctl;
   logic                                core_rst;
   logic                                core_en;
   logic                                core_done;
   logic                                wr_half;
   logic                                rd_half;
   logic                                rd_take;
   logic                                buf_in_ready;
   logic [1:0]                          buf_level;
   logic                                last_rect;

   // Enable comes from the comparator; it stays low at the limit so the step count cannot wrap
   assign core_en   = (s_r.step != RCR_STEP_MAX); // RULE6 RULE2
   assign core_done = (s_r.st == RCR_DONE);
   // All reset sources ORed; the stretch flop feeds back for a second cycle
   assign core_rst  = i_reset | i_screen_start_pulse | i_row_next | core_done | s_r.stretch; // RULE7 RULE8
   assign last_rect = ((s_r.rect_idx + RCR_RECT_ONE) == i_rect_count);

   // Halves swap roles with row bit zero
   assign wr_half = s_r.row[RCR_HALF_BIT]; // RULE3
   assign rd_half = !wr_half;

   // Lane strobes decoded from the sequencer state
   always_comb begin
      ctl                    = '0;
      ctl.clear_depth_store  = (s_r.st == RCR_CLEAR); // RULE11
      ctl.clear_color_accum  = (s_r.st == RCR_CLEAR) && !s_r.pass; // RULE11
      ctl.primary_ray_select = !s_r.pass; // RULE13 RULE17
      ctl.depth_store_write  = (s_r.st == RCR_DEPTH); // RULE15
      ctl.color_accumulate   = (s_r.st == RCR_ACCUM); // RULE16
      ctl.save_reflected_ray = (s_r.st == RCR_ACCUM); // RULE16
   end

   assign o_make_primary_ray  = (s_r.st == RCR_MAKE); // RULE12
   assign o_intersect_go      = (s_r.st == RCR_SOLVE); // RULE14
   assign o_rect_addr         = s_r.rect_idx;
   assign o_active_rectangle  = s_r.rect; // RULE10
   assign o_row_index         = s_r.row;
   assign o_column_step_index = s_r.step;
   assign o_line_half_select  = wr_half;
   assign o_core_enable       = core_en;
   assign o_core_done         = core_done;

   // Read requests are taken only when the buffer has room for the word in flight
   assign o_rd_ready = buf_in_ready && !(s_r.rd_pend && buf_level != 2'h0);
   assign rd_take    = i_rd_valid && o_rd_ready;

   // Next-state: counters, stretch flop, sequencer and read pipeline
   always_comb begin
      s_nxt         = s_r;
      // Stretch captures the sources only; taking its own output would latch it high forever
      s_nxt.stretch = i_reset | i_screen_start_pulse | i_row_next | core_done; // RULE8
      s_nxt.rd_pend = rd_take;
      if (rd_take) begin
         s_nxt.rd_data = lbuf[rd_half][i_rd_col]; // RULE9
      end
      // Row counter advances per row; screen start returns it to zero
      if (i_screen_start_pulse) begin
         s_nxt.row = RCR_ROW_ZERO; // RULE1
      end else if (i_row_next) begin
         s_nxt.row = s_r.row + RCR_ROW_ONE;
      end
      // Step counter: reset per screen and row, frozen at the limit
      if (i_screen_start_pulse || i_row_next) begin
         s_nxt.step = RCR_STEP_ZERO; // RULE1
      end else if (core_done && core_en) begin
         s_nxt.step = s_r.step + RCR_STEP_ONE; // RULE5 RULE6
      end
      unique case (s_r.st)
         RCR_IDLE: begin
            if (core_en) begin
               s_nxt.st   = RCR_CLEAR;
               s_nxt.pass = 1'b0;
            end
         end
         RCR_CLEAR: begin
            s_nxt.rect_idx = RCR_RECT_ZERO;
            s_nxt.st = s_r.pass ? RCR_FETCH : RCR_MAKE; // RULE11
         end
         RCR_MAKE: begin
            s_nxt.st = RCR_FETCH; // RULE12
         end
         RCR_FETCH: begin
            s_nxt.rect = i_rect_data; // RULE10
            s_nxt.st   = RCR_SOLVE;
         end
         RCR_SOLVE: begin
            if (i_hit_done) begin
               s_nxt.st = RCR_DEPTH; // RULE14
            end
         end
         RCR_DEPTH: begin
            if (last_rect) begin
               s_nxt.st = RCR_ACCUM; // RULE16
            end else begin
               s_nxt.rect_idx = s_r.rect_idx + RCR_RECT_ONE; // RULE10
               s_nxt.st       = RCR_FETCH;
            end
         end
         RCR_ACCUM: begin
            if (!s_r.pass) begin
               s_nxt.pass = 1'b1; // RULE17
               s_nxt.st   = RCR_CLEAR;
            end else begin
               s_nxt.st = RCR_DONE;
            end
         end
         RCR_DONE: begin
            s_nxt.st = RCR_IDLE; // RULE5
         end
      endcase
      // Core reset overrides the sequencer on the next edge
      if (core_rst) begin
         s_nxt.st   = RCR_IDLE; // RULE7
         s_nxt.pass = 1'b0;
      end
   end

   // Reset parks the step counter at the limit so the core waits for a screen start
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         s_r      <= '0;
         s_r.st   <= RCR_IDLE;
         s_r.step <= RCR_STEP_MAX; // RULE19
      end else if (i_ce) begin
         s_r <= s_nxt;
      end
   end

   // All lane sections written together; lane l owns pixels l*limit onward
   always_ff @(posedge i_clk) begin
      if (i_ce && core_done && core_en) begin
         for (int l = 0; l < RCR_LANES; l++) begin
            lbuf[wr_half][RCR_COL_W'(l * RCR_STEP_LIMIT) + RCR_COL_W'(s_r.step)] <= lane_color[l]; // RULE4 RULE5
         end
      end
   end

   // One lane per parallel ray, all driven by the single sequencer
   generate
      for (genvar g = 0; g < RCR_LANES; g++) begin : g_lane
         rcr_ray_lane u_lane (
            .i_clk         (i_clk),
            .i_reset       (i_reset),
            .i_ce          (i_ce),
            .i_ctl         (ctl),
            .i_primary_ray (i_primary_ray[g]),
            .i_hit         (i_hit[g]),
            .o_solver_ray  (o_solver_ray[g]),
            .o_color       (lane_color[g])
         );
      end
   endgenerate

   // Two entries let the scan-out stall without losing a word already read
   rcr_pair_buffer #(
      .W     (RCR_COLOR_W),
      .DEPTH (RCR_BUF_DEPTH)
   ) u_rdbuf (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_ce    (i_ce),
      .i_valid (s_r.rd_pend),
      .o_ready (buf_in_ready),
      .i_data  (s_r.rd_data),
      .o_valid (o_pix_valid),
      .i_ready (i_pix_ready),
      .o_data  (o_pix_color),
      .o_level (buf_level)
   );

   // Checks
   a_start_clears: assert property (@(posedge i_clk) disable iff (i_reset || !i_ce)
      i_screen_start_pulse |=> (s_r.row == RCR_ROW_ZERO && s_r.step == RCR_STEP_ZERO && s_r.st == RCR_IDLE)) // RULE1
      else $error("screen start did not clear counters and core");
   a_step_limit_value: assert property (@(posedge i_clk) disable iff (i_reset)
      s_r.step <= RCR_STEP_MAX) // RULE2
      else $error("step counter passed the limit");
   a_halves_apart: assert property (@(posedge i_clk) disable iff (i_reset || !i_ce)
      (rd_take && !i_screen_start_pulse && !i_row_next) |=> (rd_half == !$past(wr_half))) // RULE3
      else $error("read and write share a line half");
   a_done_steps: assert property (@(posedge i_clk) disable iff (i_reset || !i_ce)
      (core_done && core_en && !i_screen_start_pulse && !i_row_next)
      |=> (s_r.step == $past(s_r.step) + RCR_STEP_ONE) && (s_r.st == RCR_IDLE)) // RULE5
      else $error("done did not step the counter and reset the core");
   a_limit_freezes: assert property (@(posedge i_clk) disable iff (i_reset || !i_ce)
      (!core_en && !i_screen_start_pulse && !i_row_next) |=> (!core_en && s_r.st == RCR_IDLE)) // RULE6
      else $error("core ran or counter moved at the limit");
   a_reset_two_cycles: assert property (@(posedge i_clk) disable iff (i_reset || !i_ce)
      core_done |-> core_rst ##1 core_rst ##1 (s_r.st == RCR_IDLE)) // RULE8
      else $error("core reset not held two cycles");
   a_reset_idles: assert property (@(posedge i_clk) disable iff (i_reset || !i_ce)
      s_r.stretch |-> (s_r.st == RCR_IDLE) || $past(s_r.st == RCR_DONE)) // RULE7
      else $error("core left idle while reset stretched");
   a_clear_first: assert property (@(posedge i_clk) disable iff (i_reset || !i_ce)
      (s_r.st == RCR_IDLE && !core_rst && core_en)
      |=> ctl.clear_depth_store && ctl.clear_color_accum ##1 o_make_primary_ray) // RULE11 RULE12
      else $error("pixel did not start with clears and primary ray");
   a_accum_after_last: assert property (@(posedge i_clk) disable iff (i_reset || !i_ce)
      (s_r.st == RCR_DEPTH && last_rect && !core_rst) |=> ctl.color_accumulate && ctl.save_reflected_ray) // RULE16
      else $error("accumulate missing after last rectangle");
   a_second_pass_refl: assert property (@(posedge i_clk) disable iff (i_reset || !i_ce)
      (s_r.st == RCR_ACCUM && !s_r.pass && !core_rst) |=> s_r.pass ##1 !ctl.primary_ray_select) // RULE17 RULE13
      else $error("reflection pass did not select stored ray");
   a_go_until_hit: assert property (@(posedge i_clk) disable iff (i_reset || !i_ce)
      (o_intersect_go && !i_hit_done && !core_rst) |=> o_intersect_go) // RULE14
      else $error("intersect strobe dropped before hit");

   c_pixel_done:  cover property (@(posedge i_clk) disable iff (i_reset) core_done);
   c_reach_limit: cover property (@(posedge i_clk) disable iff (i_reset) core_done ##1 !core_en);
   c_reflection:  cover property (@(posedge i_clk) disable iff (i_reset) ctl.color_accumulate && s_r.pass);
   c_read_stall:  cover property (@(posedge i_clk) disable iff (i_reset) o_pix_valid && !i_pix_ready ##1 !o_rd_ready);
endmodule : rcr_renderer

/* File: tb/rcr_far_model.sv */
// Far side: ray maker, rectangle store and hit solver.
// Assumes the renderer's clock; i_delay sets the solver wait.
`timescale 1ns/1ps
module rcr_far_model
   import rcr_pkg::*;
(
   input  wire logic                     i_clk,
   input  wire logic [1:0]               i_delay,
   input  wire logic                     i_go,
   input  wire logic [RCR_STEP_W-1:0]    i_step,
   input  wire rcr_ray_t [RCR_LANES-1:0] i_ray,
   input  wire logic [RCR_RECT_AW-1:0]   i_addr,
   output rcr_ray_t [RCR_LANES-1:0]      o_primary,
   output logic                          o_done,
   output rcr_hit_t [RCR_LANES-1:0]      o_hit,
   output rcr_rect_t                     o_rect
);
   logic [1:0] wait_r;
   // Ray x is the screen column, so every colour traces back to it
   always_comb begin
      for (int l = 0; l < RCR_LANES; l++) begin
         o_primary[l]   = '0;
         o_primary[l].x = RCR_COORD_W'(i_step + l * RCR_STEP_LIMIT);
      end
   end
   // Answer after a variable wait; held until the next answer
   always_ff @(posedge i_clk) begin
      o_done <= 1'b0;
      o_rect <= '0;
      o_rect.color <= 8'(i_addr);
      if (!i_go || o_done) begin
         wait_r <= i_delay;
      end else if (wait_r != 2'h0) begin
         wait_r <= wait_r - 2'h1;
      end else begin
         o_done <= 1'b1;
         for (int l = 0; l < RCR_LANES; l++) begin
            o_hit[l]        <= '0;
            o_hit[l].refl.x <= i_ray[l].x + 9'h007;
            o_hit[l].depth  <= {7'h00, i_delay};
            o_hit[l].color  <= {1'b0, i_ray[l].x[5:0], 1'b0};
         end
      end
   end
endmodule : rcr_far_model

/* File: tb/test_rcr_renderer.sv */
// Bench for rcr_renderer: renders rows, reads the idle half with stalls.
// Assumes rcr_far_model answers for ray maker, store and solver.
`timescale 1ns/1ps
module test_rcr_renderer
   import rcr_pkg::*;
;
   logic i_clk, i_reset, i_ce, i_screen_start_pulse, i_row_next, i_rd_valid, o_rd_ready;
   logic i_pix_ready, o_pix_valid, o_line_half_select, o_make_primary_ray, o_intersect_go;
   logic i_hit_done, o_core_enable, o_core_done, took;
   logic [RCR_COL_W-1:0]   i_rd_col;
   logic [RCR_COLOR_W-1:0] o_pix_color, exp_q[$];
   logic [RCR_ROW_W-1:0]   o_row_index;
   logic [RCR_STEP_W-1:0]  o_column_step_index;
   logic [RCR_RECT_AW-1:0] i_rect_count, o_rect_addr;
   logic [1:0]             delay;
   rcr_rect_t              i_rect_data, o_active_rectangle;
   rcr_ray_t [RCR_LANES-1:0] i_primary_ray, o_solver_ray;
   rcr_hit_t [RCR_LANES-1:0] i_hit;
   int error_cnt = 0, checks_done = 0, seed = 32'haf87, dones = 0, gap = -1, reads = 0;
   rcr_renderer dut (.i_clk, .i_reset, .i_ce, .i_screen_start_pulse, .i_row_next, .i_rd_valid,
      .o_rd_ready, .i_rd_col, .o_pix_valid, .i_pix_ready, .o_pix_color, .o_line_half_select,
      .o_make_primary_ray, .o_row_index, .o_column_step_index, .i_primary_ray, .i_rect_count,
      .o_rect_addr, .i_rect_data, .o_intersect_go, .o_active_rectangle, .o_solver_ray,
      .i_hit_done, .i_hit, .o_core_enable, .o_core_done);
   rcr_far_model far (.i_clk, .i_delay(delay), .i_go(o_intersect_go), .i_step(o_column_step_index),
      .i_ray(o_solver_ray), .i_addr(o_rect_addr), .o_primary(i_primary_ray), .o_done(i_hit_done),
      .o_hit(i_hit), .o_rect(i_rect_data));
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   task automatic chk(string n, logic [8:0] e, logic [8:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s expected %0h seen %0h", n, e, g);
      end
   endtask : chk
   // Primary colour and reflected colour averaged; both even so no rounding
   function automatic logic [7:0] pix_exp(logic [8:0] c);
      logic [8:0] r;
      r = c + 9'h007;
      return 8'(c[5:0]) + 8'(r[5:0]);
   endfunction : pix_exp
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : stop_test
   // Column count and restart spacing: done, stretched reset, idle, clear, make
   // Sampled just before each rising edge, where inputs and outputs have settled
   always @(negedge i_clk) begin
      #12;
      if (o_core_done === 1'b1) begin
         dones++;
         gap = 0;
      end else if (gap >= 0) begin
         gap++;
      end
      if (o_make_primary_ray === 1'b1 && gap > 0) begin
         chk("restart gap", 9'h004, 9'(gap));
         gap = -1;
      end
      if (i_rd_valid && o_rd_ready === 1'b1) begin
         exp_q.push_back(pix_exp(i_rd_col));
         took = 1'b1;
         reads++;
      end
      if (o_pix_valid === 1'b1 && i_pix_ready)
         chk("pixel", 9'(exp_q.pop_front()), 9'(o_pix_color));
   end
   // Random reads and consumer stalls; a request holds until taken
   task automatic read_phase(int n);
      logic [8:0] corner [4] = '{9'h000, 9'h09f, 9'h0a0, 9'h13f};
      reads = 0;
      for (int t = 0; t < 3000 && reads < n; t++) begin
         @(negedge i_clk);
         if (!i_rd_valid || took) begin
            i_rd_valid = 1'($random(seed));
            i_rd_col = (reads < 4) ? corner[reads] : 9'(($random(seed) & 32'hffff) % 320);
         end
         took = 1'b0;
         i_pix_ready = 1'($random(seed));
      end
      i_rd_valid = 1'b0;
      i_pix_ready = 1'b1;
      repeat (8) @(negedge i_clk);
      chk("words lost", 9'h000, 9'(exp_q.size()));
   endtask : read_phase
   task automatic run_row(int r);
      for (int t = 0; t < 20000 && o_core_enable !== 1'b0; t++) begin
         @(negedge i_clk);
         delay = 2'($random(seed));
      end
      chk("columns", 9'(RCR_STEP_MAX), 9'(dones));
      chk("step frozen", 9'(RCR_STEP_MAX), 9'(o_column_step_index));
      chk("row", 9'(r), 9'(o_row_index));
      $display("test row %0d done", r);
   endtask : run_row
   initial begin
      i_reset = 1'b1;
      i_ce = 1'b1;
      i_screen_start_pulse = 1'b0;
      i_row_next = 1'b0;
      i_rd_valid = 1'b0;
      i_rd_col = '0;
      i_pix_ready = 1'b1;
      i_rect_count = 4'h1;
      delay = 2'h0;
      took = 1'b0;
      repeat (3) @(negedge i_clk);
      i_reset = 1'b0;
      chk("enable idle", 9'h000, 9'(o_core_enable));
      chk("pixel idle", 9'h000, 9'(o_pix_valid));
      $display("test reset done");
      for (int r = 0; r < 3; r++) begin
         i_rect_count = 4'(r + 1);
         dones = 0;
         gap = -1;
         i_screen_start_pulse = (r == 0);
         i_row_next = (r != 0);
         @(negedge i_clk);
         i_screen_start_pulse = 1'b0;
         i_row_next = 1'b0;
         chk("half select", 9'(r % 2), 9'(o_line_half_select));
         if (r > 0)
            read_phase(40);
         run_row(r);
      end
      stop_test();
   end
   // Rows take about 3000 to 6600 cycles, growing with the rectangle count; allow ample margin
   initial begin
      #2000000;
      error_cnt++;
      stop_test();
   end
endmodule : test_rcr_renderer
